//--- qdi_pkg.sv
// Purpose: Shared constants for the quad input debounce image block
// Assumes: 200 MHz clock
// Notes: Times are in ns; cycle counts are derived from them
package qdi_pkg;
  localparam int QDI_CHANNELS = 4;
  localparam int QDI_CLK_PERIOD_NS = 5;
  localparam int QDI_FILTER_TIME_NS = 3000000;
  localparam int QDI_FILTER_CYCLES =
    (QDI_FILTER_TIME_NS + QDI_CLK_PERIOD_NS - 1) / QDI_CLK_PERIOD_NS;
  localparam int QDI_FLASH_HZ = 2;
  localparam int QDI_FLASH_HALF_NS = 1000000000 / (2 * QDI_FLASH_HZ);
  localparam int QDI_FLASH_HALF_CYCLES = QDI_FLASH_HALF_NS / QDI_CLK_PERIOD_NS;
  localparam int QDI_FILTER_CNT_W = 20;
  localparam int QDI_FLASH_CNT_W = 26;
  localparam int QDI_ADDR_W = 4;
  localparam logic [3:0] QDI_IMAGE_OFFSET = 4'h0;
  localparam logic [7:0] QDI_IMAGE_RESET = 8'h00;
  localparam int QDI_IMAGE_CH_LSB = 0;
  localparam logic [3:0] QDI_IMAGE_RSVD = 4'h0;

  typedef enum logic [1:0] {
    QDI_FAULT_OFF   = 2'b00,
    QDI_FAULT_ON    = 2'b01,
    QDI_FAULT_FLASH = 2'b10
  } qdi_fault_type;
endpackage

//--- qdi_chan_if.sv
// Purpose: Carries one channel between the top and its filter
// Assumes: Single clock domain
// Notes: Raw level in, filtered level out
`timescale 1ns/1ps
interface qdi_chan_if;
  logic raw;
  logic filtered;
  modport filt (input raw, output filtered);
  modport top (output raw, input filtered);
endinterface

//--- qdi_filter.sv
// Purpose: Symmetric delay filter for one input channel
// Assumes: Input synchronous to clk_i
// Notes: Output follows only after the new level persists CYCLES clocks
`timescale 1ns/1ps
module qdi_filter
  import qdi_pkg::*;
#(
  parameter int CYCLES = QDI_FILTER_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Channel
  qdi_chan_if.filt ch
);
  logic [QDI_FILTER_CNT_W-1:0] cnt;
  logic state;

  // Same counter serves both edge directions
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cnt <= '0;
      state <= 1'b0;
    end
    else if (ch.raw == state)
    begin
      cnt <= '0;
    end
    else if (cnt == QDI_FILTER_CNT_W'(CYCLES - 1))
    begin
      state <= ch.raw; // [R1] [R2]
      cnt <= '0;
    end
    else
    begin
      cnt <= cnt + QDI_FILTER_CNT_W'(1);
    end
  end

  assign ch.filtered = state;
endmodule

//--- qdi_top.sv
// Purpose: Four-channel filtered input image with status indicators
// Assumes: Inputs synchronous to clk_i; coupler reads the image byte
// Notes: Read-only; no output, parameter or diagnostic data
//
// Functional notes
// [R1] Rising change shows in image only after 3 ms stable high.
// [R2] Falling change shows in image only after 3 ms stable low.
// [R3] Image byte: bits 0..3 carry channels 0..3, bits 7..4 reserved.
// [R4] No output image bytes; the coupler cannot alter behaviour.
// [R5] All four channels filtered concurrently and independently.
// [R6] Each channel indicator lit while its input is one.
// [R7] Run indicator shows whether bus communication works.
// [R8] Fault indicator lit on module error, dark when fine.
// [R9] Fault indicator flashes at 2 Hz on configuration error.
// [R10] Reserved image bits read zero; no interrupt or diagnostic record.
`timescale 1ns/1ps
module qdi_top
  import qdi_pkg::*;
#(
  parameter int FILTER_CYCLES = QDI_FILTER_CYCLES,
  parameter int FLASH_HALF_CYCLES = QDI_FLASH_HALF_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Process inputs
  input wire logic [QDI_CHANNELS-1:0] input_channel_n_i,
  // Coupler read port
  input wire logic rd_i,
  input wire logic [QDI_ADDR_W-1:0] addr_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [7:0] input_image_area_o,
  // Module status
  input wire logic bus_ok_i,
  input wire logic module_error_i,
  input wire logic config_error_i,
  // Indicators
  output logic [QDI_CHANNELS-1:0] channel_led_o,
  output logic run_led_o,
  output logic module_fault_indicator_o
);
  logic [QDI_CHANNELS-1:0] filtered;
  logic [7:0] channel_state_byte;
  logic [QDI_FLASH_CNT_W-1:0] flash_cnt;
  logic flash_phase;
  logic flash_wrap;
  qdi_fault_type fault_mode;
  qdi_fault_type next_fault_mode;

  // One independent filter per channel
  genvar g;
  generate
    for (g = 0; g < QDI_CHANNELS; g++)
    begin : gen_ch
      qdi_chan_if chi ();
      assign chi.raw = input_channel_n_i[g];
      assign filtered[g] = chi.filtered;
      qdi_filter #(.CYCLES(FILTER_CYCLES)) u_filt ( // [R5]
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ch(chi)
      );
    end
  endgenerate

  // Packs filtered levels under the cleared reserved nibble
  function automatic logic [7:0] pack_image(input logic [QDI_CHANNELS-1:0] lvl);
  begin
    pack_image = {QDI_IMAGE_RSVD, lvl}; // [R3] [R10]
  end
  endfunction

  // Only the image offset is mapped
  function automatic logic image_hit(input logic rd, input logic [QDI_ADDR_W-1:0] addr);
  begin
    image_hit = rd && (addr == QDI_IMAGE_OFFSET);
  end
  endfunction

  // Image byte
  assign channel_state_byte = pack_image(filtered); // [R3]

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      input_image_area_o <= QDI_IMAGE_RESET;
    end
    else
    begin
      input_image_area_o <= channel_state_byte; // [R3]
    end
  end

  // Read answer strobe, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_i;
    end
  end

  // Read data; no write path exists
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= QDI_IMAGE_RESET;
    end
    else if (image_hit(rd_i, addr_i))
    begin
      rdata_o <= channel_state_byte; // [R3]
    end
    else
    begin
      rdata_o <= 8'h00; // [R4]
    end
  end

  // Channel indicators follow the raw pins
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      channel_led_o <= '0;
    end
    else
    begin
      channel_led_o <= input_channel_n_i; // [R6]
    end
  end

  // Run indicator
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      run_led_o <= 1'b0;
    end
    else
    begin
      run_led_o <= bus_ok_i; // [R7]
    end
  end

  // Flash timebase
  assign flash_wrap = (flash_cnt == QDI_FLASH_CNT_W'(FLASH_HALF_CYCLES - 1));

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || flash_wrap)
    begin
      flash_cnt <= '0;
    end
    else
    begin
      flash_cnt <= flash_cnt + QDI_FLASH_CNT_W'(1);
    end
  end

  // Flash phase, free running from reset
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      flash_phase <= 1'b0;
    end
    else if (flash_wrap)
    begin
      flash_phase <= ~flash_phase; // [R9]
    end
  end

  // Fault indicator mode
  always_comb
  begin
    if (config_error_i)
    begin
      next_fault_mode = QDI_FAULT_FLASH; // [R9]
    end
    else if (module_error_i)
    begin
      next_fault_mode = QDI_FAULT_ON; // [R8]
    end
    else
    begin
      next_fault_mode = QDI_FAULT_OFF; // [R8]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      fault_mode <= QDI_FAULT_OFF;
    end
    else
    begin
      fault_mode <= next_fault_mode;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      module_fault_indicator_o <= 1'b0;
    end
    else
    begin
      case (fault_mode)
        QDI_FAULT_ON: module_fault_indicator_o <= 1'b1; // [R8]
        QDI_FAULT_FLASH: module_fault_indicator_o <= flash_phase; // [R9]
        default: module_fault_indicator_o <= 1'b0;
      endcase
    end
  end
endmodule

//--- qdi_top_properties.sv
// Purpose: Port checks for qdi_top
// Assumes: FILTER_CYCLES 8, FLASH_HALF_CYCLES 4
// Notes: Bound into qdi_top
`timescale 1ns/1ps
module qdi_top_check
(
  // Watched ports
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] input_channel_n_i,
  input wire logic rd_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [7:0] input_image_area_o,
  input wire logic bus_ok_i,
  input wire logic module_error_i,
  input wire logic config_error_i,
  input wire logic [3:0] channel_led_o,
  input wire logic run_led_o,
  input wire logic module_fault_indicator_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  rise_filter_a: assert property (
    $rose(input_channel_n_i[0]) && !input_image_area_o[0] ##1 input_channel_n_i[0] [*7]
    |=> ##1 input_image_area_o[0]) else $error("channel 0 rise not shown in time");
  rise_early_a: assert property (
    $rose(input_channel_n_i[0]) && !input_image_area_o[0] |=> !input_image_area_o[0] [*8])
    else $error("channel 0 rise shown too early");
  fall_filter_a: assert property (
    $fell(input_channel_n_i[3]) && input_image_area_o[3] ##1 !input_channel_n_i[3] [*7]
    |=> ##1 !input_image_area_o[3]) else $error("channel 3 fall not shown in time");
  reserved_zero_a: assert property (
    input_image_area_o[7:4] == 4'h0 && rdata_o[7:4] == 4'h0)
    else $error("reserved image bits not zero");
  unmapped_read_a: assert property (
    rd_i && addr_i != 4'h0 |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  image_read_a: assert property (
    rd_i && addr_i == 4'h0 |=> rdata_o == input_image_area_o) else $error("image read wrong");
  read_strobe_a: assert property (
    $past(rstn_i) |-> rvalid_o == $past(rd_i)) else $error("read strobe wrong");
  channel_led_a: assert property (
    $past(rstn_i) |-> channel_led_o == $past(input_channel_n_i))
    else $error("channel indicator wrong");
  run_led_a: assert property (
    $past(rstn_i) |-> run_led_o == $past(bus_ok_i)) else $error("run indicator wrong");
  fault_steady_a: assert property (
    (!config_error_i && $stable(module_error_i)) [*4]
    |=> module_fault_indicator_o == $past(module_error_i))
    else $error("fault indicator not steady");
  fault_flash_a: assert property (
    config_error_i [*5] ##1 config_error_i && $changed(module_fault_indicator_o)
    ##1 config_error_i [*4] |-> $changed(module_fault_indicator_o)
    && $past(module_fault_indicator_o) == $past(module_fault_indicator_o, 4))
    else $error("fault indicator flash period wrong");
endmodule
bind qdi_top qdi_top_check chk_u (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .input_channel_n_i(input_channel_n_i),
  .rd_i(rd_i),
  .addr_i(addr_i),
  .rdata_o(rdata_o),
  .rvalid_o(rvalid_o),
  .input_image_area_o(input_image_area_o),
  .bus_ok_i(bus_ok_i),
  .module_error_i(module_error_i),
  .config_error_i(config_error_i),
  .channel_led_o(channel_led_o),
  .run_led_o(run_led_o),
  .module_fault_indicator_o(module_fault_indicator_o)
);

//--- qdi_coupler.sv
// Purpose: Coupler model reading the image byte
// Assumes: One read at a time
// Notes: Address is inverted when idle
`timescale 1ns/1ps
module qdi_coupler
(
  // Read port
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic rd_o = 1'b0,
  output logic [3:0] addr_o = 4'hf
);
  task automatic read(input logic [3:0] a, output logic [7:0] d, output logic v);
  begin
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    d = rdata_i;
    v = rvalid_i;
    rd_o = 1'b0;
    addr_o = ~a;
    @(posedge clk_i);
    #1;
  end
  endtask
endmodule

//--- tb_top.sv
// Purpose: Self-checking bench for qdi_top
// Assumes: Short filter and flash counts
// Notes: Inputs move 1 ns after the edge
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] input_channel_n_i = 4'h0;
  logic bus_ok_i = 1'b0;
  logic module_error_i = 1'b0;
  logic config_error_i = 1'b0;
  logic rd_i, rvalid_o, run_led_o, module_fault_indicator_o, prev;
  logic [3:0] addr_i, channel_led_o;
  logic [7:0] rdata_o, input_image_area_o;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  always #2.5 clk_i = ~clk_i;
  qdi_top #(.FILTER_CYCLES(8), .FLASH_HALF_CYCLES(4)) uut (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .input_channel_n_i(input_channel_n_i),
    .rd_i(rd_i),
    .addr_i(addr_i),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .input_image_area_o(input_image_area_o),
    .bus_ok_i(bus_ok_i),
    .module_error_i(module_error_i),
    .config_error_i(config_error_i),
    .channel_led_o(channel_led_o),
    .run_led_o(run_led_o),
    .module_fault_indicator_o(module_fault_indicator_o)
  );
  qdi_coupler cpl (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .rd_o(rd_i),
    .addr_o(addr_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
  begin
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
  begin
    cpl.read(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  end
  endtask
  task automatic wt(input int k);
  begin
    repeat (k) @(posedge clk_i);
    #1;
  end
  endtask
  task automatic test_done();
  begin
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    wt(3);
    rstn_i = 1'b1;
    rd_chk(4'h0, 8'h00);
    $display("reset test done");
    input_channel_n_i = 4'hf;
    wt(1);
    chk({4'h0, channel_led_o}, 8'h0f);
    wt(6);
    input_channel_n_i = 4'hd;
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h0, 8'h0d);
    chk(input_image_area_o, 8'h0d);
    rd_chk(4'h5, 8'h00);
    $display("rise test done");
    input_channel_n_i = 4'h0;
    wt(7);
    rd_chk(4'h0, 8'h0d);
    rd_chk(4'h0, 8'h00);
    chk(input_image_area_o, 8'h00);
    $display("fall test done");
    bus_ok_i = 1'b1;
    wt(1);
    chk({7'h00, run_led_o}, 8'h01);
    bus_ok_i = 1'b0;
    module_error_i = 1'b1;
    wt(4);
    chk({7'h00, run_led_o}, 8'h00);
    chk({7'h00, module_fault_indicator_o}, 8'h01);
    module_error_i = 1'b0;
    wt(4);
    chk({7'h00, module_fault_indicator_o}, 8'h00);
    config_error_i = 1'b1;
    wt(6);
    n = 0;
    repeat (16)
    begin
      prev = module_fault_indicator_o;
      wt(1);
      n += (module_fault_indicator_o !== prev);
    end
    chk(n[7:0], 8'h04);
    $display("status test done");
    test_done();
  end
endmodule
